// ### rtl/multi_device_clock_sync.sv
// Purpose: Aligns the divided clock of several synthesizers to one master
// Assumes: All inputs synchronous to clk; sync_in is a master pulse train
//          or a manual edge source, depending on mode
// Notes:   Control writes land in a buffer and act only after an update
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "mdsync_params.svh"

// Summary of operation
// - Master drives one-clock sync pulse every four clocks
// - Slave enable makes device watch sync input
// - Slave stalls one clock on phase mismatch
// - Slave aligns within three divided-clock periods
// - Two-bit offset compensates zero to three clocks delay
// - Offset field resets to zero
// - Slave sets sticky flag on lost alignment
// - Reading the flag clears it
// - Flag stays set after alignment regained
// - Mask bit forces flag to zero
// - Update clearing software sync bit stalls once
// - Each stall shifts divided clock one quarter
// - Hardware sync mode stalls on sync rising edge
// - Divide by four, rising active, driven out
// - Written data idle until update transfers it
// - Update strobe sampled at divided clock rise
// - Unaligned update adds one period of uncertainty
module multi_device_clock_sync #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 24
) (
   input  logic              clk,
   input  logic              reset,
   input  logic [ADDR_W-1:0] addr,
   input  logic [DATA_W-1:0] wdata,
   input  logic              wr,
   input  logic              rd,
   output logic [DATA_W-1:0] rdata,
   input  logic              io_update,
   input  logic              sync_in,
   output logic              sync_out,
   output logic              sync_clk
);

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
      return a == t;
   endfunction

   phase_if ph ();

   phase_gen u_gen (
      .clk   (clk),
      .reset (reset),
      .bus   (ph.gen)
   );

   // Buffered (written) and active copies of the two control registers
   logic [DATA_W-1:0]          fc1_buf;
   logic [DATA_W-1:0]          fc2_buf;
   logic [DATA_W-1:0]          fc1_act;
   logic [DATA_W-1:0]          fc2_act;
   logic                       sync_lost;
   logic                       sync_in_prev;
   mdsync_pkg::stall_cause_t   last_cause;
   mdsync_pkg::stall_cause_t   next_cause;
   logic                       next_lost;
   logic                       next_sync_out;
   logic [DATA_W-1:0]          next_rdata;

   // Register port decode
   wire wr_fc1 = wr && hit(addr, ADDR_W'(`FC1_ADDR));
   wire wr_fc2 = wr && hit(addr, ADDR_W'(`FC2_ADDR));
   wire rd_fc1 = rd && hit(addr, ADDR_W'(`FC1_ADDR));
   wire rd_fc2 = rd && hit(addr, ADDR_W'(`FC2_ADDR));
   wire rd_st  = rd && hit(addr, ADDR_W'(`STATUS_ADDR));

   // Active control bits
   wire                 ctl_sw     = fc1_act[`FC1_SW_SYNC];
   wire                 ctl_hw     = fc1_act[`FC1_HW_SYNC];
   wire                 ctl_master = fc2_act[`FC2_MASTER];
   wire                 ctl_slave  = fc2_act[`FC2_SLAVE];
   wire                 ctl_mask   = fc2_act[`FC2_MASK];
   wire [1:0]           ctl_offset = fc2_act[`FC2_OFS_HI:`FC2_OFS_LO];

   // Edge of the sync input; it serves both the slave compare and manual hardware mode
   wire                 in_rise    = sync_in && !sync_in_prev;

   // Master phase seen at the slave: pin lag plus programmed propagation offset
   wire mdsync_pkg::phase_t expected = 2'(`PIN_LAG + ctl_offset);

   // The update strobe only acts on a divided-clock rising edge
   wire                 update_now = ph.rise_tick && io_update;

   // Each mismatch costs one clock, so a quarter-period error closes
   // within three master pulses
   wire auto_miss = ctl_slave && !ctl_hw && in_rise && (ph.phase != expected);

   // Stall only on the update that turns the software sync bit off
   wire sw_stall  = update_now && ctl_sw && !fc1_buf[`FC1_SW_SYNC];

   wire hw_stall  = ctl_hw && in_rise;

   assign ph.stall = auto_miss || sw_stall || hw_stall;

   // Status flag: mask dominates, then a new miss, then the read clear
   always_comb begin
      if (ctl_mask) begin
         next_lost = 1'b0;
      end else if (auto_miss) begin
         next_lost = 1'b1;
      end else if (rd_fc2) begin
         next_lost = 1'b0;
      end else begin
         next_lost = sync_lost;
      end
   end

   always_comb begin
      if (auto_miss) begin
         next_cause = mdsync_pkg::cause_auto;
      end else if (sw_stall) begin
         next_cause = mdsync_pkg::cause_sw;
      end else if (hw_stall) begin
         next_cause = mdsync_pkg::cause_hw;
      end else begin
         next_cause = last_cause;
      end
   end

   // Only the first cycle of phase zero pulses, so a stall cannot stretch it
   assign next_sync_out = ctl_master && (ph.phase == `PHASE_PULSE) && !sync_out;

   always_comb begin
      next_rdata = '0;
      if (rd_fc1) begin
         next_rdata = fc1_buf;
      end else if (rd_fc2) begin
         next_rdata = fc2_buf;
         next_rdata[`FC2_STATUS] = sync_lost;
      end else if (rd_st) begin
         next_rdata[`ST_PHASE_HI:`ST_PHASE_LO] = ph.phase;
         next_rdata[`ST_CAUSE_HI:`ST_CAUSE_LO] = 2'(last_cause);
      end
   end

   // Buffer writes; they have no effect on behaviour yet
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fc1_buf <= `FC1_RESET;
         fc2_buf <= `FC2_RESET;
      end else begin
         if (wr_fc1) begin
            fc1_buf <= wdata;
         end
         if (wr_fc2) begin
            fc2_buf <= wdata;
         end
      end
   end

   // An asynchronous strobe may miss one edge and land a period later
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fc1_act <= `FC1_RESET;
         fc2_act <= `FC2_RESET;
      end else if (update_now) begin
         fc1_act <= fc1_buf;
         fc2_act <= fc2_buf;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_lost    <= 1'b0;
         last_cause   <= mdsync_pkg::cause_none;
         // Idle level of the pulled-up pin, so release brings no false edge
         sync_in_prev <= 1'b1;
      end else begin
         sync_lost    <= next_lost;
         last_cause   <= next_cause;
         sync_in_prev <= sync_in;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata    <= '0;
         sync_out <= 1'b0;
         sync_clk <= 1'b0;
      end else begin
         rdata    <= next_rdata;
         sync_out <= next_sync_out;
         sync_clk <= ph.phase[1];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_master_width: assert property (
      $rose(sync_out) |=> !sync_out)
      else $error("master sync pulse wider than one clock");

   chk_master_period: assert property (
      ctl_master && ph.phase == `PHASE_PULSE && !ph.stall && !sync_out
      ##1 (ctl_master && !ph.stall) [*3] |-> ##2 sync_out)
      else $error("master sync pulse not repeating every four clocks");

   chk_auto_stall: assert property (
      ctl_slave && !ctl_hw && $rose(sync_in) && ph.phase != expected
      |=> ph.phase == $past(ph.phase))
      else $error("slave did not stall on mismatch");

   chk_loss_flag: assert property (
      auto_miss && !ctl_mask |=> sync_lost ##0 (!rd_fc2 && !ctl_mask) |=> sync_lost)
      else $error("sync loss not flagged or not held");

   chk_mask_hold: assert property (
      ctl_mask |=> !sync_lost)
      else $error("masked status flag not held low");

   chk_read_clear: assert property (
      rd_fc2 && !auto_miss && sync_lost |=> !sync_lost && rdata[`FC2_STATUS])
      else $error("reading status did not return and clear flag");

   chk_flag_sticky: assert property (
      sync_lost && !rd_fc2 && !ctl_mask |=> sync_lost)
      else $error("status flag dropped without read");

   chk_update_hold: assert property (
      !(ph.rise_tick && io_update) |=> fc1_act == $past(fc1_act) && fc2_act == $past(fc2_act))
      else $error("active registers changed without update");

   chk_update_load: assert property (
      ph.rise_tick && io_update |=> fc2_act == $past(fc2_buf))
      else $error("update on divided clock edge did not load buffer");

   chk_sw_stall: assert property (
      update_now && ctl_sw && !fc1_buf[`FC1_SW_SYNC]
      |=> ph.phase == $past(ph.phase) && !ctl_sw)
      else $error("software sync update did not stall once");

   chk_hw_stall: assert property (
      ctl_hw && $rose(sync_in) |=> ph.phase == $past(ph.phase))
      else $error("hardware sync edge did not stall divider");

   chk_clk_out: assert property (
      $rose(ph.phase[1]) |=> $rose(sync_clk) ##1 sync_clk)
      else $error("divided clock output does not follow divider");

endmodule

// ### rtl/mdsync_params.svh
// Purpose: Named offsets, bit positions, reset values and phase codes
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef MDSYNC_PARAMS_SVH
`define MDSYNC_PARAMS_SVH

// Register word offsets on the plain register port
`define FC1_ADDR      8'h01
`define FC2_ADDR      8'h02
`define STATUS_ADDR   8'h03

// Bits of function_control_one
`define FC1_SW_SYNC   0
`define FC1_HW_SYNC   1

// Bits of function_control_two
`define FC2_OFS_LO    0
`define FC2_OFS_HI    1
`define FC2_MASK      4
`define FC2_STATUS    5
`define FC2_MASTER    6
`define FC2_SLAVE     7

// Fields of the status word
`define ST_PHASE_LO   0
`define ST_PHASE_HI   1
`define ST_CAUSE_LO   2
`define ST_CAUSE_HI   3

// Reset values
`define FC1_RESET     24'h000000
`define FC2_RESET     24'h000000
`define PHASE_RESET   2'h0

// Divided clock phases (system clock divided by four)
`define PHASE_PULSE   2'h0
`define PHASE_RISE    2'h2
`define PHASE_STEP    2'h1
`define PIN_LAG       2'h2

`endif

// ### rtl/mdsync_pkg.sv
// Purpose: Shared types of the multi-device clock alignment block
// Assumes: Nothing beyond the parameter header
// Notes:   Used only through scoped names
package mdsync_pkg;

   typedef logic [1:0] phase_t;

   typedef enum {
      cause_none,
      cause_auto,
      cause_sw,
      cause_hw
   } stall_cause_t;

endpackage

// ### rtl/phase_if.sv
// Purpose: Carries the stall request and divider phase between modules
// Assumes: One clock domain
// Notes:   rise_tick is a one-cycle enable on each divided-clock rising edge
`timescale 1ns/1ns

interface phase_if;
   logic                stall;
   mdsync_pkg::phase_t  phase;
   logic                rise_tick;

   modport gen  (input stall, output phase, output rise_tick);
   modport user (output stall, input phase, input rise_tick);
endinterface

// ### rtl/phase_gen.sv
// Purpose: Divide-by-four phase counter that can be held for one cycle
// Assumes: stall is a level for the current cycle only
// Notes:   A held cycle moves the divided clock by a quarter period
`timescale 1ns/1ns
`include "mdsync_params.svh"

module phase_gen (
   input  logic         clk,
   input  logic         reset,
   phase_if.gen         bus
);

   mdsync_pkg::phase_t next_phase;
   logic               next_rise;

   assign next_phase = bus.stall ? bus.phase : 2'(bus.phase + `PHASE_STEP);
   assign next_rise  = (next_phase == `PHASE_RISE) && (bus.phase != `PHASE_RISE);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus.phase     <= `PHASE_RESET;
         bus.rise_tick <= 1'b0;
      end else begin
         bus.phase     <= next_phase;
         bus.rise_tick <= next_rise;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_divider_step: assert property (
      !bus.stall ##1 !bus.stall ##1 !bus.stall |=> bus.phase == $past(bus.phase, 3) + 2'h3)
      else $error("divider did not advance by one per cycle");

   chk_stall_hold: assert property (
      bus.stall |=> bus.phase == $past(bus.phase) ##1 !$past(bus.stall)
                    |-> bus.phase != $past(bus.phase))
      else $error("stall did not hold the phase for exactly one cycle");

   chk_rise_tick: assert property (
      bus.rise_tick |-> bus.phase == `PHASE_RISE && $past(bus.phase) != `PHASE_RISE)
      else $error("rise tick not aligned to divided clock edge");

endmodule

// ### bench/master_sync_model.sv
// Purpose: Far-side master device driving the sync line of the block
// Assumes: Shares clk with the block under test
// Notes:   Released line idles high, as the sync input has a pull-up; the pulse train rests low
`timescale 1ns/1ns

module master_sync_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic train_en,
   input  wire logic hold,
   input  wire logic edge_req,
   output logic      sync_line
);
   logic [1:0] cnt;
   logic       pulse;

   // Start so the pulse train lands on block phase PIN_LAG, the expected phase at offset zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 2'h3;
         pulse <= 1'b0;
      end else begin
         if (!hold) cnt <= cnt + 2'h1;
         pulse <= (cnt == 2'h0) && !hold;
      end
   end

   // Released line rests high; edge_req pulls low once for a rising edge
   assign sync_line = train_en ? pulse : !edge_req;
endmodule

// ### bench/test_multi_device_clock_sync.sv
// Purpose: Self-checking bench for the multi-device clock alignment block
// Assumes: Bus strobes driven right after rising edges
// Notes:   Stalls are counted as five-clock gaps between divided-clock rises
`timescale 1ns/1ns
`include "mdsync_params.svh"

module test_multi_device_clock_sync;
   logic        clk;
   logic        reset;
   logic [7:0]  addr;
   logic [23:0] wdata;
   logic        wr;
   logic        rd;
   logic [23:0] rdata;
   logic        io_update;
   logic        sync_line;
   logic        sync_out;
   logic        sync_clk;
   logic        train_en;
   logic        hold;
   logic        edge_req;
   logic        prev_clk;
   logic        prev_out;
   logic [23:0] d;
   int          gap;
   int          long_gaps;
   int          rises;
   int          pulses;
   int          doubles;
   int          cycles;
   int          g0;
   int          miscompares;
   int          compares;

   multi_device_clock_sync u_multi_device_clock_sync (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .io_update(io_update),
      .sync_in(sync_line), .sync_out(sync_out), .sync_clk(sync_clk));

   master_sync_model u_master_sync_model (.clk(clk), .reset(reset), .train_en(train_en),
      .hold(hold), .edge_req(edge_req), .sync_line(sync_line));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Monitor of divided-clock rises, stall gaps and master pulses
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
      prev_clk <= sync_clk;
      prev_out <= sync_out;
      pulses <= pulses + int'(sync_out === 1'b1);
      doubles <= doubles + int'(sync_out === 1'b1 && prev_out === 1'b1);
      if (sync_clk === 1'b1 && prev_clk === 1'b0) begin
         rises <= rises + 1;
         long_gaps <= long_gaps + int'(gap == 5);
         gap <= 1;
      end else begin
         gap <= gap + 1;
      end
   end

   task automatic print_verdict();
      if (miscompares == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [23:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [23:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // Held past one divided-clock period so a rise tick always sees it
   task automatic update();
      @(posedge clk);
      io_update <= 1'b1;
      repeat (5) @(posedge clk);
      io_update <= 1'b0;
   endtask

   task automatic pulse_line(input bit use_hold);
      @(posedge clk);
      if (use_hold) hold <= 1'b1;
      else edge_req <= 1'b1;
      @(posedge clk);
      hold <= 1'b0;
      edge_req <= 1'b0;
   endtask

   task automatic t_reset();
      rd_reg(`FC1_ADDR, d);
      check(d, `FC1_RESET);
      rd_reg(`FC2_ADDR, d);
      check(d, `FC2_RESET);
      g0 = rises;
      wait_n(16);
      check(24'(rises - g0), 24'h4);
   endtask

   task automatic t_master();
      g0 = pulses;
      wr_reg(`FC2_ADDR, 24'h000040);
      wait_n(12);
      check(24'(pulses - g0), 24'h0);
      update();
      wait_n(8);
      g0 = pulses;
      wait_n(16);
      check(24'(pulses - g0), 24'h4);
      check(24'(doubles), 24'h0);
      wr_reg(`FC2_ADDR, 24'h000000);
      update();
   endtask

   task automatic t_manual();
      g0 = long_gaps;
      wr_reg(`FC1_ADDR, 24'h000001);
      update();
      wr_reg(`FC1_ADDR, 24'h000000);
      update();
      wait_n(8);
      check(24'(long_gaps - g0), 24'h1);
      wr_reg(`FC1_ADDR, 24'h000002);
      update();
      wait_n(8);
      g0 = long_gaps;
      pulse_line(1'b0);
      wait_n(8);
      pulse_line(1'b0);
      wait_n(8);
      check(24'(long_gaps - g0), 24'h2);
      rd_reg(`STATUS_ADDR, d);
      check(24'(d[`ST_CAUSE_HI:`ST_CAUSE_LO]), 24'h3);
      wr_reg(`FC1_ADDR, 24'h000000);
      update();
   endtask

   task automatic t_slave();
      train_en <= 1'b1;
      wr_reg(`FC2_ADDR, 24'h000080);
      update();
      wait_n(24);
      rd_reg(`FC2_ADDR, d);
      g0 = long_gaps;
      wait_n(16);
      check(24'(long_gaps - g0), 24'h0);
      pulse_line(1'b1);
      wait_n(16);
      check(24'(long_gaps != g0), 24'h1);
      g0 = long_gaps;
      wait_n(16);
      check(24'(long_gaps - g0), 24'h0);
      rd_reg(`FC2_ADDR, d);
      check(24'(d[`FC2_STATUS]), 24'h1);
      rd_reg(`FC2_ADDR, d);
      check(24'(d[`FC2_STATUS]), 24'h0);
      wr_reg(`FC2_ADDR, 24'h000090);
      update();
      wait_n(8);
      pulse_line(1'b1);
      wait_n(24);
      rd_reg(`FC2_ADDR, d);
      check(24'(d[`FC2_STATUS]), 24'h0);
      // Offset code 01 moves the expected master phase one clock later
      g0 = long_gaps;
      wr_reg(`FC2_ADDR, 24'h000081);
      update();
      wait_n(24);
      check(24'(long_gaps != g0), 24'h1);
      g0 = long_gaps;
      wait_n(16);
      check(24'(long_gaps - g0), 24'h0);
   endtask

   initial begin
      {addr, wdata, wr, rd, io_update, train_en, hold, edge_req} = '0;
      {gap, long_gaps, rises, pulses, doubles, cycles} = '0;
      {prev_clk, prev_out, miscompares, compares} = '0;
      reset = 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_master();
      t_manual();
      t_slave();
      print_verdict();
   end
endmodule
